// ---- hdl/bridge_pkg.sv ----
// constants, field codes and timing counts shared by the bridge control logic
// assumes one 50 MHz core clock and no register bus: all settings arrive as ports
package bridge_pkg;
    localparam int          CLK_HZ            = 50_000_000;
    localparam int          NUM_BRIDGES       = 4;
    localparam int          PWM_STEPS         = 512;
    localparam int          PWM_CNT_W         = 9;
    localparam int          PWM_FREQ_HZ       = 31250;
    // whole-cycle length of one pwm step at the core clock rate, at least one
    localparam int          PWM_TICK_RAW      = CLK_HZ / (PWM_FREQ_HZ * PWM_STEPS);
    localparam int          PWM_TICK_CYC      = (PWM_TICK_RAW < 1) ? 1 : PWM_TICK_RAW;
    localparam int          PWM_TICK_W        = 4;
    localparam int          PWM_PHASE_STEP    = PWM_STEPS / NUM_BRIDGES;
    localparam int          OC_FILTER_NS      = 2000;
    localparam int          OC_FILTER_CYC     = (OC_FILTER_NS * (CLK_HZ / 1_000_000)
                                                 + 999) / 1000;
    localparam int          OC_CNT_W          = 8;
    localparam int          TOFF_CNT_W        = 12;
    localparam int          DEAD_NS           = 100;
    localparam int          DEAD_CYC          = (DEAD_NS * (CLK_HZ / 1_000_000)
                                                 + 999) / 1000;
    localparam int          DEAD_EXTRA_NS     = 40;
    localparam int          DEAD_EXTRA_CYC    = (DEAD_EXTRA_NS * (CLK_HZ / 1_000_000)
                                                 + 999) / 1000;
    localparam int          DEAD_CNT_W        = 4;
    localparam logic [1:0]  SRC_INTERNAL      = 2'h0;
    localparam logic [1:0]  SRC_AUX           = 2'h1;
    localparam logic [1:0]  SRC_EXT_LO        = 2'h2;
    localparam logic [1:0]  SRC_EXT_HI        = 2'h3;
    localparam logic [1:0]  CFG_FULL          = 2'h0;
    localparam logic [1:0]  CFG_HALF          = 2'h2;
    localparam logic [1:0]  PAIR_INDEPENDENT  = 2'h0;
    localparam logic [1:0]  PAIR_PARALLEL     = 2'h1;
    typedef enum logic [1:0] {MODE_FULL, MODE_HALF, MODE_SWITCH} bridge_mode_e;
endpackage

// ---- hdl/ext_pwm_sync.sv ----
// two-stage synchronisers for the four gpio-supplied pwm inputs
// assumes the pins are asynchronous to core_clk
`timescale 1ns/1ns
module ext_pwm_sync
    import bridge_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       resetn,
    // raw pins
    input  wire logic [3:0] pins,
    // synchronised levels
    pwm_bus_if.producer     sync_out
);
    logic [3:0] meta_q;
    logic [3:0] stable_q;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            meta_q   <= 4'h0;
            stable_q <= 4'h0;
        end else begin
            meta_q   <= pins;
            stable_q <= meta_q;
        end
    end

    assign sync_out.ext_pwm = stable_q;
endmodule

// ---- hdl/motor_bridge_control.sv ----
// four h-bridge control: pwm sources, configuration decode, gating and faults
// assumes controller settings are synchronous levels and fault inputs are clean levels
`timescale 1ns/1ns
module motor_bridge_control
    import bridge_pkg::*;
(
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   resetn,
    // system conditions
    input  wire logic                   system_reset_n,
    input  wire logic                   thermal_shutdown,
    input  wire logic                   low_power_mode,
    input  wire logic [3:0]             over_current,
    input  wire logic [3:0]             current_limit,
    // controller settings: per-bridge fields, pair modes, toff and over-current clear
    input  wire logic [3:0]             enable_set,
    input  wire logic [3:0]             side_a_drive_control,
    input  wire logic [3:0]             side_b_drive_control,
    input  wire logic [7:0]             side_a_pwm_source_sel,
    input  wire logic [7:0]             side_b_pwm_source_sel,
    input  wire logic [7:0]             bridge_config_sel,
    input  wire logic [35:0]            bridge_internal_duty,
    input  wire logic [3:0]             bridge_auxiliary_pwm,
    input  wire logic                   bridges_first_pair_parallel,
    input  wire logic [1:0]             bridges_second_pair_config,
    input  wire logic [TOFF_CNT_W-1:0]  current_limit_toff,
    input  wire logic                   over_current_clear,
    // gpio pwm pins
    input  wire logic                   external_pwm_in_1,
    input  wire logic                   external_pwm_in_2,
    input  wire logic                   external_pwm_in_3,
    input  wire logic                   external_pwm_in_4,
    // power stage controls: drive level and enable per half bridge, and the shared dead time
    output logic [3:0]                  out_pos_level,
    output logic [3:0]                  out_pos_drive,
    output logic [3:0]                  out_neg_level,
    output logic [3:0]                  out_neg_drive,
    output logic [DEAD_CNT_W-1:0]       dead_time_cycles,
    // status
    output logic                        over_current_flag,
    output logic [3:0]                  enabled_status,
    output logic                        stepper_mode
);
    pwm_bus_if ext_bus ();

    logic [PWM_TICK_W-1:0] tick_cnt_q;
    logic                  step_tick;
    logic [3:0]            bridge_internal_pwm;
    logic [3:0]            en_q;
    logic [3:0]            en_set_q;
    logic                  fault_kill;
    logic [OC_CNT_W-1:0]   oc_cnt_q [NUM_BRIDGES];
    logic                  oc_trip;
    logic                  oc_flag_q;
    logic [3:0]            cl_active;
    logic [TOFF_CNT_W-1:0] toff_q [NUM_BRIDGES];
    logic                  pair2_parallel;
    logic [3:0]            pwm_a;
    logic [3:0]            pwm_b;
    logic [3:0]            pos_lvl_d;
    logic [3:0]            pos_drv_d;
    logic [3:0]            neg_lvl_d;
    logic [3:0]            neg_drv_d;
    logic [3:0]            pos_lvl_q;
    logic [3:0]            pos_drv_q;
    logic [3:0]            neg_lvl_q;
    logic [3:0]            neg_drv_q;

    ext_pwm_sync u_sync (
        .core_clk (core_clk),
        .resetn   (resetn),
        .pins     ({external_pwm_in_4, external_pwm_in_3,
                    external_pwm_in_2, external_pwm_in_1}),
        .sync_out (ext_bus.producer)
    );

    // shared step tick keeps all four generators on one time base
    always_ff @(posedge core_clk) begin
        if (!resetn || tick_cnt_q == PWM_TICK_W'(PWM_TICK_CYC - 1)) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 4'h1;
        end
    end
    assign step_tick = (tick_cnt_q == PWM_TICK_W'(PWM_TICK_CYC - 1));

    genvar g;
    generate
        for (g = 0; g < NUM_BRIDGES; g++) begin : gen_bridge
            pwm_gen #(
                .PHASE (PWM_CNT_W'(g * PWM_PHASE_STEP))
            ) u_gen (
                .core_clk  (core_clk),
                .resetn    (resetn),
                .step_tick (step_tick),
                .duty      (bridge_internal_duty[g*PWM_CNT_W +: PWM_CNT_W]),
                .pwm_out   (bridge_internal_pwm[g])
            );

            // over-current must persist through the filter before it trips
            always_ff @(posedge core_clk) begin
                if (!resetn || !over_current[g]) begin
                    oc_cnt_q[g] <= '0;
                end else if (oc_cnt_q[g] != OC_CNT_W'(OC_FILTER_CYC)) begin
                    oc_cnt_q[g] <= oc_cnt_q[g] + 8'h01;
                end
            end

            // current limit: latched, then held off for the programmed toff
            always_ff @(posedge core_clk) begin
                if (!resetn) begin
                    toff_q[g] <= '0;
                end else if (current_limit[g]) begin
                    toff_q[g] <= current_limit_toff;
                end else if (toff_q[g] != '0) begin
                    toff_q[g] <= toff_q[g] - 12'h001;
                end
            end
            assign cl_active[g] = current_limit[g] || (toff_q[g] != '0);

            // per-half source selection, gpio pairs differ between the two pairs
            logic [3:0] cand;
            assign cand = {((g < 2) ? ext_bus.ext_pwm[1:0] : ext_bus.ext_pwm[3:2]),
                           bridge_auxiliary_pwm[g],
                           bridge_internal_pwm[g]};

            // every source is an argument, so the assigns below track each of them
            function automatic logic pick(input logic [1:0] sel, input logic [3:0] srcs);
                unique case (sel)
                    SRC_INTERNAL: pick = srcs[0];
                    SRC_AUX:      pick = srcs[1];
                    SRC_EXT_LO:   pick = srcs[2];
                    SRC_EXT_HI:   pick = srcs[3];
                endcase
            endfunction
            assign pwm_a[g] = pick(side_a_pwm_source_sel[2*g +: 2], cand);
            assign pwm_b[g] = pick(side_b_pwm_source_sel[2*g +: 2], cand);
        end
    endgenerate

    assign oc_trip = (oc_cnt_q[0] == OC_CNT_W'(OC_FILTER_CYC))
                  || (oc_cnt_q[1] == OC_CNT_W'(OC_FILTER_CYC))
                  || (oc_cnt_q[2] == OC_CNT_W'(OC_FILTER_CYC))
                  || (oc_cnt_q[3] == OC_CNT_W'(OC_FILTER_CYC));

    // flag: a new trip wins over a clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            oc_flag_q <= 1'b0;
        end else if (oc_trip) begin
            oc_flag_q <= 1'b1;
        end else if (over_current_clear) begin
            oc_flag_q <= 1'b0;
        end
    end

    assign fault_kill = oc_trip || thermal_shutdown || !system_reset_n;

    // enables arm on a rising write level so a fault clear cannot re-arm by itself
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            en_set_q <= 4'h0;
        end else begin
            en_set_q <= enable_set;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn || fault_kill) begin
            en_q <= 4'h0;
        end else begin
            en_q <= (en_q | (enable_set & ~en_set_q)) & enable_set;
        end
    end

    assign pair2_parallel = (bridges_second_pair_config == PAIR_PARALLEL);
    assign stepper_mode   = bridges_second_pair_config[1];

    // output decode; bridge 2 (4) follows bridge 1 (3) when paralleled
    always_comb begin
        int          src;
        logic        gate_off;
        logic        ca;
        logic        cb;
        logic        pw;
        logic [1:0]  cfg;
        src       = 0;
        gate_off  = 1'b0;
        ca        = 1'b0;
        cb        = 1'b0;
        pw        = 1'b0;
        cfg       = 2'h0;
        pos_lvl_d = 4'h0;
        pos_drv_d = 4'h0;
        neg_lvl_d = 4'h0;
        neg_drv_d = 4'h0;
        for (int b = 0; b < NUM_BRIDGES; b++) begin
            src = b;
            if (b == 1 && bridges_first_pair_parallel) begin
                src = 0;
            end
            if (b == 3 && pair2_parallel) begin
                src = 2;
            end
            cfg      = bridge_config_sel[2*src +: 2];
            ca       = side_a_drive_control[src];
            cb       = side_b_drive_control[src];
            gate_off = thermal_shutdown || !system_reset_n || low_power_mode
                    || !en_q[src] || cl_active[src] || cl_active[b];
            if (b >= 2 && stepper_mode) begin
                gate_off = 1'b1;   // stepper sequencer owns these bridges
            end
            if (!gate_off && cfg == CFG_FULL) begin
                pw = pwm_a[src];
                pos_drv_d[b] = 1'b1;
                neg_drv_d[b] = 1'b1;
                if (ca == cb) begin
                    pos_lvl_d[b] = ca;
                    neg_lvl_d[b] = ca;
                end else if (!pw) begin
                    pos_lvl_d[b] = 1'b1;
                    neg_lvl_d[b] = 1'b1;
                end else begin
                    pos_lvl_d[b] = ca;
                    neg_lvl_d[b] = cb;
                end
            end else if (!gate_off && cfg == CFG_HALF) begin
                pos_drv_d[b] = pwm_a[src];
                pos_lvl_d[b] = ca;
                neg_drv_d[b] = pwm_b[src];
                neg_lvl_d[b] = cb;
            end else if (!gate_off) begin                        // switch
                pos_drv_d[b] = ca;
                pos_lvl_d[b] = !pwm_a[src];
                neg_drv_d[b] = cb;
                neg_lvl_d[b] = !pwm_b[src];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pos_lvl_q <= 4'h0;
            pos_drv_q <= 4'h0;
            neg_lvl_q <= 4'h0;
            neg_drv_q <= 4'h0;
        end else begin
            pos_lvl_q <= pos_lvl_d;
            pos_drv_q <= pos_drv_d;
            neg_lvl_q <= neg_lvl_d;
            neg_drv_q <= neg_drv_d;
        end
    end

    // paralleled paths skew slightly, so the power stage gets a wider gap
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            dead_time_cycles <= DEAD_CNT_W'(DEAD_CYC);
        end else if (bridges_first_pair_parallel || pair2_parallel) begin
            dead_time_cycles <= DEAD_CNT_W'(DEAD_CYC + DEAD_EXTRA_CYC);
        end else begin
            dead_time_cycles <= DEAD_CNT_W'(DEAD_CYC);
        end
    end

    assign out_pos_level     = pos_lvl_q;
    assign out_pos_drive     = pos_drv_q;
    assign out_neg_level     = neg_lvl_q;
    assign out_neg_drive     = neg_drv_q;
    assign over_current_flag = oc_flag_q;
    assign enabled_status    = en_q;
endmodule

// ---- hdl/pwm_bus_if.sv ----
// carries synchronised external pwm levels from the input stage to the bridge logic
// assumes one clock domain; the producer already ran the levels through two flops
`timescale 1ns/1ns
interface pwm_bus_if;
    logic [3:0] ext_pwm;
    modport producer (output ext_pwm);
    modport consumer (input  ext_pwm);
endinterface

// ---- hdl/pwm_gen.sv ----
// one internal pwm generator: 512 steps per period, starting at a fixed phase
// assumes the shared step tick and the duty value are synchronous to core_clk
`timescale 1ns/1ns
module pwm_gen
    import bridge_pkg::*;
#(
    parameter logic [PWM_CNT_W-1:0] PHASE = '0
) (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 resetn,
    // timing and setting
    input  wire logic                 step_tick,
    input  wire logic [PWM_CNT_W-1:0] duty,
    // output
    output logic                      pwm_out
);
    logic [PWM_CNT_W-1:0] cnt_q;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            cnt_q <= PHASE;
        end else if (step_tick) begin
            cnt_q <= cnt_q + 9'h001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pwm_out <= 1'b0;
        end else begin
            pwm_out <= (cnt_q < duty);
        end
    end
endmodule

// ---- tb/mcu_model.sv ----
// controller-side model: owns the bridge enables and drives the gpio pwm pins
// assumes the bench clock; every change lands on the falling edge like the bench's own
`timescale 1ns/1ns
module mcu_model (
    // clock
    input  wire logic       core_clk,
    // commands from the bench
    input  wire logic [3:0] arm_req,
    input  wire logic [3:0] drop,
    input  wire logic [3:0] pin_cmd,
    // towards the device
    output logic [3:0]      enable_set = 4'h0,
    output logic [3:0]      ext_pins = 4'h0
);
    logic [3:0] pend_q = 4'h0;
    // an arm first lowers the enable for a cycle, so the device always sees a fresh edge
    always @(negedge core_clk) begin
        enable_set <= (enable_set & ~arm_req & ~drop) | pend_q;
        pend_q <= arm_req & ~drop;
        ext_pins <= pin_cmd;
    end
endmodule

// ---- tb/motor_bridge_control_monitor.sv ----
// assertion checker for the four-bridge control block, bound to its top module
// assumes one core clock domain and the synchronous active-low resetn
`timescale 1ns/1ns
module motor_bridge_control_monitor
    import bridge_pkg::*;
(
    // clock and reset
    input wire logic                  core_clk,
    input wire logic                  resetn,
    // conditions and settings
    input wire logic                  system_reset_n,
    input wire logic                  thermal_shutdown,
    input wire logic                  low_power_mode,
    input wire logic [3:0]            over_current,
    input wire logic [3:0]            current_limit,
    input wire logic                  over_current_clear,
    input wire logic                  bridges_first_pair_parallel,
    input wire logic [1:0]            bridges_second_pair_config,
    // outputs
    input wire logic [3:0]            out_pos_drive,
    input wire logic [3:0]            out_neg_drive,
    input wire logic [3:0]            enabled_status,
    input wire logic [DEAD_CNT_W-1:0] dead_time_cycles,
    input wire logic                  over_current_flag
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    logic [3:0] drv;
    logic [7:0] run_q [4];
    logic       ripe;
    logic       late;
    assign drv = out_pos_drive | out_neg_drive;
    // saturating run length, so a very long event cannot wrap back to zero
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < 4; i++) begin
            if (!resetn || !over_current[i]) run_q[i] <= 8'h00;
            else if (run_q[i] != 8'hFF) run_q[i] <= run_q[i] + 8'h01;
        end
    end
    always_comb begin
        ripe = 1'b0;
        late = 1'b0;
        for (int i = 0; i < 4; i++) begin
            ripe = ripe | (int'(run_q[i]) >= OC_FILTER_CYC - 1);
            late = late | (int'(run_q[i]) >= OC_FILTER_CYC + 2);
        end
    end
    a_oc_filter_min: assert property ($rose(over_current_flag) |-> ripe)
        else $error("over-current flag rose before the filter time");
    a_oc_filter_max: assert property ($rose(late) |-> over_current_flag)
        else $error("over-current flag missing after the filter time");
    a_oc_flag_sticky: assert property (over_current_flag && !over_current_clear |=> over_current_flag)
        else $error("over-current flag dropped without a clear");
    a_oc_all_off: assert property ($rose(over_current_flag) |=> drv == 4'h0)
        else $error("bridges still driven after an over-current trip");
    a_tsd_all_off: assert property (thermal_shutdown [*2] |=> drv == 4'h0 && enabled_status == 4'h0)
        else $error("bridges driven or enabled during thermal shutdown");
    a_sysrst_all_off: assert property (!system_reset_n [*2] |=> drv == 4'h0 && enabled_status == 4'h0)
        else $error("bridges driven or enabled during system reset");
    a_lowpwr_off: assert property (low_power_mode [*2] |=> drv == 4'h0)
        else $error("bridges driven in low-power mode");
    a_climit_off: assert property (current_limit[0] [*2] |=> !drv[0])
        else $error("bridge driven during current limit");
    a_drive_needs_arm: assert property (drv[0] |-> $past(enabled_status[0]))
        else $error("bridge driven without being enabled");
    a_dead_parallel: assert property ((bridges_first_pair_parallel || bridges_second_pair_config == PAIR_PARALLEL) [*2] |=> dead_time_cycles == DEAD_CYC + DEAD_EXTRA_CYC)
        else $error("dead time not lengthened while paralleled");
    a_dead_normal: assert property ((!bridges_first_pair_parallel && bridges_second_pair_config != PAIR_PARALLEL) [*2] |=> dead_time_cycles == DEAD_CYC)
        else $error("dead time wrong while not paralleled");
    a_stepper_off: assert property (bridges_second_pair_config[1] [*2] |=> drv[3:2] == 2'h0)
        else $error("bridges 3 or 4 driven in stepper mode");
    c_oc_trip: cover property ($rose(over_current_flag));
    c_dead_long: cover property (dead_time_cycles == DEAD_CYC + DEAD_EXTRA_CYC);
    c_par_drive: cover property (bridges_first_pair_parallel && drv[1:0] == 2'h3);
endmodule

bind motor_bridge_control motor_bridge_control_monitor motor_bridge_control_monitor_inst (
    .core_clk(core_clk), .resetn(resetn), .system_reset_n(system_reset_n),
    .thermal_shutdown(thermal_shutdown), .low_power_mode(low_power_mode),
    .over_current(over_current), .current_limit(current_limit),
    .over_current_clear(over_current_clear),
    .bridges_first_pair_parallel(bridges_first_pair_parallel),
    .bridges_second_pair_config(bridges_second_pair_config),
    .out_pos_drive(out_pos_drive), .out_neg_drive(out_neg_drive),
    .enabled_status(enabled_status), .dead_time_cycles(dead_time_cycles),
    .over_current_flag(over_current_flag)
);

// ---- tb/motor_bridge_control_tb_top.sv ----
// self-checking bench for the four-bridge control block and its controller model
// assumes one-cycle setting latency and three-cycle gpio pwm latency at the outputs
`timescale 1ns/1ns
module motor_bridge_control_tb_top
    import bridge_pkg::*;
;
    localparam logic [1:0] TT [8] = '{2'h0, 2'h0, 2'h3, 2'h1, 2'h3, 2'h2, 2'h3, 2'h3};
    logic                  core_clk, resetn, system_reset_n, thermal_shutdown;
    logic                  low_power_mode, par, oc_clear, flag, stepper;
    logic [3:0]            oc, cl, ca, cb, aux, arm, drop, pins, enable, ext;
    logic [3:0]            pd, pl, nd, nl, en_st;
    logic [7:0]            sel_a, sel_b, cfg;
    logic [1:0]            pair2;
    logic [35:0]           duty;
    logic [DEAD_CNT_W-1:0] dead;
    int                    n_fail, comparisons, hi, eq;

    mcu_model mcu_model_inst (
        .core_clk(core_clk), .arm_req(arm), .drop(drop), .pin_cmd(pins),
        .enable_set(enable), .ext_pins(ext)
    );
    motor_bridge_control motor_bridge_control_inst (
        .core_clk(core_clk), .resetn(resetn), .system_reset_n(system_reset_n),
        .thermal_shutdown(thermal_shutdown), .low_power_mode(low_power_mode),
        .over_current(oc), .current_limit(cl), .enable_set(enable),
        .side_a_drive_control(ca), .side_b_drive_control(cb),
        .side_a_pwm_source_sel(sel_a), .side_b_pwm_source_sel(sel_b),
        .bridge_config_sel(cfg), .bridge_internal_duty(duty),
        .bridge_auxiliary_pwm(aux), .bridges_first_pair_parallel(par),
        .bridges_second_pair_config(pair2), .current_limit_toff(12'h014),
        .over_current_clear(oc_clear), .external_pwm_in_1(ext[0]),
        .external_pwm_in_2(ext[1]), .external_pwm_in_3(ext[2]),
        .external_pwm_in_4(ext[3]), .out_pos_level(pl), .out_pos_drive(pd),
        .out_neg_level(nl), .out_neg_drive(nd), .dead_time_cycles(dead),
        .over_current_flag(flag), .enabled_status(en_st), .stepper_mode(stepper)
    );

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // drive bit and level of both sides of one bridge, packed as pos drive/level, neg drive/level
    task automatic br(input string what, input int b, input logic [3:0] exp);
        check(what, {12'h000, pd[b], pl[b], nd[b], nl[b]}, {12'h000, exp});
    endtask
    task automatic arm_up(input logic [3:0] m);
        arm <= m;
        cyc(1);
        arm <= 4'h0;
        cyc(5);
    endtask
    task automatic tally_and_finish();
        if (n_fail == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // the whole sequence needs about 1840 cycles
    initial begin
        cyc(6000);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        {resetn, thermal_shutdown, low_power_mode, par, oc_clear} = '0;
        system_reset_n = 1'b1;
        {oc, cl, ca, cb, aux, arm, drop, pins} = '0;
        {sel_a, sel_b, cfg, pair2, duty} = '0;
        n_fail = 0;
        comparisons = 0;
        cyc(2);
        resetn <= 1'b1;
        cyc(3);
        check("dead_time", 16'(dead), 16'(DEAD_CYC));
        br("idle", 0, 4'h0);
        {ca, cb} <= 8'h11;
        arm_up(4'h1);
        check("enabled", 16'(en_st), 16'h0001);
        br("both_high", 0, 4'hF);
        {ca, cb} <= 8'h00;
        cyc(3);
        br("both_low", 0, 4'hA);
        // side a takes aux, side b stays on a silent internal source
        sel_a <= 8'h01;
        for (int k = 2; k < 8; k++) begin
            {ca[0], cb[0], aux[0]} <= 3'(k);
            cyc(3);
            br("one_side", 0, {1'b1, TT[k][1], 1'b1, TT[k][0]});
        end
        {ca, cb, aux} <= {4'h5, 4'h0, 4'h0};
        arm_up(4'h4);
        // only the selected pin carries the level, the others the inverse
        for (int k = 0; k < 8; k++) begin
            sel_a <= 8'(2 + k[1]) << (4 * k[2]);
            pins <= {4{~k[0]}} ^ 4'(1 << (2 * k[2] + k[1]));
            cyc(6);
            br("ext_pwm", 2 * k[2], {3'h7, ~k[0]});
        end
        sel_a <= 8'h00;
        duty <= {9'h000, 9'h100, 9'h000, 9'h100};
        cyc(4);
        hi = 0;
        eq = 0;
        repeat (PWM_STEPS * PWM_TICK_CYC) begin
            cyc(1);
            hi += int'(nl[0] === 1'b0);
            eq += int'(nl[0] === nl[2]);
        end
        check("duty_cycles", 16'(hi), 16'(256 * PWM_TICK_CYC));
        check("phase_overlap", 16'(eq), 16'h0000);
        duty <= '0;
        cl <= 4'h1;
        cyc(2);
        cl <= 4'h0;
        cyc(10);
        check("climit_off", {12'h000, pd[0], nd[0], pd[2], nd[2]}, 16'h0003);
        cyc(20);
        check("climit_back", {14'h0000, pd[0], nd[0]}, 16'h0003);
        // switch, half, then the other switch code: side a on aux held high, side b on silent internal
        {sel_a, aux} <= {8'h01, 4'h1};
        for (int k = 1; k < 4; k++) begin
            cfg <= 8'(k);
            cyc(3);
            br("cfg_mode", 0, (k == 2) ? 4'hC : 4'h9);
        end
        {cfg, sel_a, aux} <= '0;
        for (int k = 0; k < 4; k++) begin
            thermal_shutdown <= (k == 0);
            system_reset_n <= (k != 1);
            low_power_mode <= (k == 2);
            drop <= {3'h0, k == 3};
            cyc(3);
            check("gated_drive", {14'h0000, pd[0], nd[0]}, 16'h0000);
            {thermal_shutdown, low_power_mode, drop} <= '0;
            system_reset_n <= 1'b1;
            cyc(3);
            check("kept_enable", {15'h0000, en_st[0]}, 16'(k == 2));
            check("kept_drive", {14'h0000, pd[0], nd[0]}, (k == 2) ? 16'h3 : 16'h0);
            arm_up(4'h5);
        end
        oc <= 4'h1;
        cyc(OC_FILTER_CYC - 5);
        check("oc_early", {15'h0000, flag}, 16'h0000);
        cyc(10);
        check("oc_trip", {3'h0, flag, pd, nd, en_st}, 16'h1000);
        // a trip still standing wins over a clear, so the event goes away first
        oc <= 4'h0;
        cyc(2);
        check("oc_sticky", {15'h0000, flag}, 16'h0001);
        oc_clear <= 1'b1;
        cyc(1);
        oc_clear <= 1'b0;
        cyc(2);
        check("oc_clear", {15'h0000, flag}, 16'h0000);
        {ca, cb, par} <= {4'h1, 4'h1, 1'b1};
        arm_up(4'h1);
        br("par_follow", 1, 4'hF);
        check("dead_par", 16'(dead), 16'(DEAD_CYC + DEAD_EXTRA_CYC));
        {par, pair2, ca, cb} <= {1'b0, PAIR_PARALLEL, 4'h4, 4'h4};
        arm_up(4'h4);
        br("pair2_follow", 3, 4'hF);
        check("dead_pair2", 16'(dead), 16'(DEAD_CYC + DEAD_EXTRA_CYC));
        pair2 <= 2'h2;
        cyc(3);
        check("stepper", {11'h000, stepper, pd[3:2], nd[3:2]}, 16'h0010);
        tally_and_finish();
    end
endmodule
